// ==== verilog/cmac_core.sv ====
// Branch, bit and addressing core of the processor.
`timescale 1ns/100ps
`default_nettype none
module cmac_core (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        issue,
  input  wire logic [7:0]  ins_op,
  input  wire logic [7:0]  ins_arg1,
  input  wire logic [7:0]  ins_arg2,
  input  wire logic [15:0] next_pc,
  output logic             busy_q,
  output logic             done_q,
  output logic             taken_q,
  output logic [15:0]      new_pc_q,
  output logic [1:0]       ins_len_q,
  output logic             range_err_q,
  output logic             bad_op_q,
  output logic             xdata_we_q,
  output logic             code_we_q,
  output logic [15:0]      mem_addr_q,
  output logic [7:0]       mem_wdata_q
);

  // ****************************************************************
  // Architectural registers
  // ****************************************************************
  cmac_pkg::cmac_state_t state_q;
  logic [2:0]  cnt_q;
  logic [7:0]  stack_top_q;
  logic [7:0]  ptr_lo_q;
  logic [7:0]  ptr_hi_q;
  logic [7:0]  accum_q;
  logic [7:0]  mulb_q;
  logic [7:0]  flags_q;
  logic [7:0]  store_ctl_q;
  logic        pend_q;
  logic [7:0]  pend_dat_q;

  function automatic logic [7:0] fr_rd(input logic [7:0] a);
    case (a)
      cmac_pkg::FR_STACK:     fr_rd = stack_top_q;
      cmac_pkg::FR_PTR_LO:    fr_rd = ptr_lo_q;
      cmac_pkg::FR_PTR_HI:    fr_rd = ptr_hi_q;
      cmac_pkg::FR_STORE_CTL: fr_rd = store_ctl_q;
      cmac_pkg::FR_FLAGS:     fr_rd = {flags_q[7:1], ^accum_q};
      cmac_pkg::FR_ACCUM:     fr_rd = accum_q;
      cmac_pkg::FR_MULB:      fr_rd = mulb_q;
      default:                fr_rd = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] b,
                                         input logic [2:0] p,
                                         input logic       v);
    logic [7:0] r;
    r    = b;
    r[p] = v;
    put_bit = r;
  endfunction

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  wire        ok       = issue && !busy_q;
  wire [7:0]  opc      = ins_op;
  wire        cy       = flags_q[cmac_pkg::FLAGS_CY];
  wire [1:0]  bank     = {flags_q[cmac_pkg::FLAGS_BANK_HI],
                          flags_q[cmac_pkg::FLAGS_BANK_LO]};
  wire        is_cjne  = opc[7:1] == cmac_pkg::OP_CJNE_IND[7:1];
  wire        is_movi  = opc[7:1] == cmac_pkg::OP_MOV_IND_IM[7:1];
  wire        is_djnz  = opc[7:3] == cmac_pkg::OP_DJNZ_REG[7:3];
  wire        is_movr  = opc[7:3] == cmac_pkg::OP_MOV_REG_IM[7:3];
  wire        is_ajmp  = opc[4:0] == cmac_pkg::OPL_AJMP;
  wire        is_acall = opc[4:0] == cmac_pkg::OPL_ACALL;
  wire        is_cjmp  = opc == cmac_pkg::OP_JC || opc == cmac_pkg::OP_JNC
                      || opc == cmac_pkg::OP_JZ || opc == cmac_pkg::OP_JNZ;
  wire        is_jbit  = opc == cmac_pkg::OP_JB || opc == cmac_pkg::OP_JNB
                      || opc == cmac_pkg::OP_JBC;
  wire        is_bitop = opc == cmac_pkg::OP_CLR_BIT
                      || opc == cmac_pkg::OP_SETB_BIT
                      || opc == cmac_pkg::OP_CPL_BIT
                      || opc == cmac_pkg::OP_ANL_C
                      || opc == cmac_pkg::OP_ANL_NC
                      || opc == cmac_pkg::OP_ORL_C
                      || opc == cmac_pkg::OP_ORL_NC
                      || opc == cmac_pkg::OP_MOV_C_BIT
                      || opc == cmac_pkg::OP_MOV_BIT_C;
  wire        uses_bit = is_jbit || is_bitop;
  // Bank base is bank number times eight; pointers are only R0 and R1.
  wire [2:0]  reg_idx  = (is_djnz || is_movr) ? opc[2:0]
                                              : {2'b00, opc[0]};
  wire [7:0]  ra_addr  = {3'b000, bank, reg_idx};
  wire [7:0]  ra_data;
  wire [7:0]  rb_data;
  wire [7:0]  bit_adr  = ins_arg1;
  // Upper bit addresses land on the function register ending in 0 or 8.
  wire [7:0]  bit_byte = bit_adr[7] ? {bit_adr[7:3], 3'b000}
                       : cmac_pkg::BIT_BASE + {4'h0, bit_adr[6:3]};
  wire [7:0]  dir_adr  = uses_bit ? bit_byte : ins_arg1;
  wire        fr_sel   = dir_adr[7];
  wire [7:0]  rb_addr  = (is_cjne || is_movi) ? ra_data : dir_adr;
  wire [7:0]  dir_byte = fr_sel ? fr_rd(dir_adr) : rb_data;
  wire        bit_val  = dir_byte[bit_adr[2:0]];
  wire [7:0]  rel      = (is_jbit || is_cjne) ? ins_arg2 : ins_arg1;
  wire [15:0] rel_tgt  = next_pc + {{8{rel[7]}}, rel};
  wire [15:0] page_tgt = {next_pc[15:11], opc[7:5], ins_arg1};
  wire [15:0] ptr16    = {ptr_hi_q, ptr_lo_q};
  wire [15:0] jind_tgt = ptr16 + {8'h00, accum_q};
  wire [7:0]  dec_val  = ra_data - 8'h01;
  wire [7:0]  stack_inc = stack_top_q + 8'h01;
  wire        ram_we;
  wire [7:0]  ram_wa;
  wire [7:0]  ram_wd;

  cmac_data_ram u_ram (
    .mclk    (mclk),
    .we      (ram_we),
    .waddr   (ram_wa),
    .wdata   (ram_wd),
    .raddr_a (ra_addr),
    .rdata_a (ra_data),
    .raddr_b (rb_addr),
    .rdata_b (rb_data)
  );

  // ****************************************************************
  // Execution decode
  // ****************************************************************
  logic [2:0]  cyc_d;
  logic [1:0]  len_d;
  logic        jump;
  logic [15:0] tgt;
  logic        known;
  logic        wr_en;
  logic        wr_fr;
  logic [7:0]  wr_adr;
  logic [7:0]  wr_dat;
  logic        cy_d;
  logic        push;
  logic        call;
  logic        ext_wr;

  always_comb begin
    cyc_d  = cmac_pkg::CYC_ONE;
    len_d  = cmac_pkg::LEN_1;
    jump   = 1'b0;
    tgt    = next_pc;
    known  = 1'b1;
    wr_en  = 1'b0;
    wr_fr  = fr_sel;
    wr_adr = dir_adr;
    wr_dat = put_bit(dir_byte, bit_adr[2:0], 1'b0);
    cy_d   = cy;
    push   = 1'b0;
    call   = 1'b0;
    ext_wr = 1'b0;
    if (opc == cmac_pkg::OP_NOP || opc == cmac_pkg::OP_SPARE) begin
      cyc_d = cmac_pkg::CYC_ONE;
    end else if (is_cjmp) begin
      len_d = cmac_pkg::LEN_2;
      case (opc)
        cmac_pkg::OP_JC:  jump = cy;
        cmac_pkg::OP_JNC: jump = !cy;
        cmac_pkg::OP_JZ:  jump = accum_q == 8'h00;
        default:          jump = accum_q != 8'h00;
      endcase
      cyc_d = jump ? cmac_pkg::CYC_CJMP_T : cmac_pkg::CYC_CJMP_NT;
      tgt   = rel_tgt;
    end else if (is_jbit) begin
      len_d = cmac_pkg::LEN_3;
      jump  = (opc == cmac_pkg::OP_JNB) ? !bit_val : bit_val;
      wr_en = (opc == cmac_pkg::OP_JBC) && bit_val;
      cyc_d = jump ? cmac_pkg::CYC_JBIT_T : cmac_pkg::CYC_JBIT_NT;
      tgt   = rel_tgt;
    end else if (opc == cmac_pkg::OP_JMP_IND) begin
      cyc_d = cmac_pkg::CYC_JIND;
      jump  = 1'b1;
      tgt   = jind_tgt;
    end else if (is_cjne) begin
      len_d = cmac_pkg::LEN_3;
      jump  = rb_data != ins_arg1;
      cyc_d = jump ? cmac_pkg::CYC_CJNE_T : cmac_pkg::CYC_CJNE_NT;
      tgt   = rel_tgt;
    end else if (is_djnz) begin
      len_d  = cmac_pkg::LEN_2;
      wr_en  = 1'b1;
      wr_fr  = 1'b0;
      wr_adr = ra_addr;
      wr_dat = dec_val;
      jump   = dec_val != 8'h00;
      cyc_d  = jump ? cmac_pkg::CYC_DJNZ_T : cmac_pkg::CYC_DJNZ_NT;
      tgt    = rel_tgt;
    end else if (opc == cmac_pkg::OP_SJMP) begin
      len_d = cmac_pkg::LEN_2;
      cyc_d = cmac_pkg::CYC_SJMP;
      jump  = 1'b1;
      tgt   = rel_tgt;
    end else if (is_ajmp || is_acall) begin
      len_d  = cmac_pkg::LEN_2;
      cyc_d  = cmac_pkg::CYC_PAGE;
      jump   = 1'b1;
      tgt    = page_tgt;
      call   = is_acall;
      wr_en  = is_acall;
      wr_fr  = 1'b0;
      wr_adr = stack_inc;
      wr_dat = next_pc[7:0];
    end else if (opc == cmac_pkg::OP_LJMP) begin
      len_d = cmac_pkg::LEN_3;
      cyc_d = cmac_pkg::CYC_LJMP;
      jump  = 1'b1;
      tgt   = {ins_arg1, ins_arg2};
    end else if (is_bitop) begin
      len_d = cmac_pkg::LEN_2;
      cyc_d = cmac_pkg::CYC_BITOP;
      case (opc)
        cmac_pkg::OP_CLR_BIT:  wr_en = 1'b1;
        cmac_pkg::OP_SETB_BIT: begin
          wr_en  = 1'b1;
          wr_dat = put_bit(dir_byte, bit_adr[2:0], 1'b1);
        end
        cmac_pkg::OP_CPL_BIT:  begin
          wr_en  = 1'b1;
          wr_dat = put_bit(dir_byte, bit_adr[2:0], !bit_val);
        end
        cmac_pkg::OP_MOV_BIT_C: begin
          wr_en  = 1'b1;
          wr_dat = put_bit(dir_byte, bit_adr[2:0], cy);
        end
        cmac_pkg::OP_ANL_C:  cy_d = cy && bit_val;
        cmac_pkg::OP_ANL_NC: cy_d = cy && !bit_val;
        cmac_pkg::OP_ORL_C:  cy_d = cy || bit_val;
        cmac_pkg::OP_ORL_NC: cy_d = cy || !bit_val;
        default:             cy_d = bit_val;
      endcase
    end else if (opc == cmac_pkg::OP_PUSH) begin
      len_d  = cmac_pkg::LEN_2;
      cyc_d  = cmac_pkg::CYC_PUSH;
      push   = 1'b1;
      wr_en  = 1'b1;
      wr_fr  = 1'b0;
      wr_adr = stack_inc;
      wr_dat = dir_byte;
    end else if (opc == cmac_pkg::OP_MOVX_PTR) begin
      cyc_d  = cmac_pkg::CYC_MOVX;
      ext_wr = 1'b1;
    end else if (opc == cmac_pkg::OP_MOV_DIR_IM) begin
      len_d  = cmac_pkg::LEN_3;
      cyc_d  = cmac_pkg::CYC_MOV_DIR;
      wr_en  = 1'b1;
      wr_fr  = ins_arg1[7];
      wr_adr = ins_arg1;
      wr_dat = ins_arg2;
    end else if (is_movi || is_movr) begin
      len_d  = cmac_pkg::LEN_2;
      cyc_d  = cmac_pkg::CYC_MOV_2;
      wr_en  = 1'b1;
      wr_fr  = 1'b0;
      wr_adr = is_movi ? ra_data : ra_addr;
      wr_dat = ins_arg1;
    end else begin
      known = 1'b0;
    end
  end

  // Reserved code space is never entered by a jump or written; a fall-through new_pc_q is next_pc, unchecked.
  wire tgt_bad  = jump && (tgt > cmac_pkg::CODE_LIMIT);
  wire code_sel = store_ctl_q[cmac_pkg::STORE_WE];
  wire code_bad = ext_wr && code_sel && (ptr16 > cmac_pkg::CODE_LIMIT);
  wire fr_we    = ok && wr_en && wr_fr;
  assign ram_we = pend_q || (ok && wr_en && !wr_fr);
  assign ram_wa = pend_q ? stack_inc : wr_adr;
  assign ram_wd = pend_q ? pend_dat_q : wr_dat;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= cmac_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        cmac_pkg::ST_IDLE: begin
          if (ok && cyc_d == cmac_pkg::CYC_ONE) begin
            done_q <= 1'b1;
          end else if (ok) begin
            state_q <= cmac_pkg::ST_RUN;
            busy_q  <= 1'b1;
            cnt_q   <= cyc_d - 3'h1;
          end
        end
        cmac_pkg::ST_RUN: begin
          if (cnt_q == cmac_pkg::CYC_ONE) begin
            state_q <= cmac_pkg::ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: state_q <= cmac_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      taken_q     <= 1'b0;
      new_pc_q    <= 16'h0000;
      ins_len_q   <= 2'h0;
      range_err_q <= 1'b0;
      bad_op_q    <= 1'b0;
      xdata_we_q  <= 1'b0;
      code_we_q   <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
      pend_q      <= 1'b0;
      pend_dat_q  <= 8'h00;
    end else begin
      xdata_we_q <= ok && ext_wr && !code_sel;
      code_we_q  <= ok && ext_wr && code_sel && !code_bad;
      pend_q     <= ok && call;
      if (ok) begin
        taken_q     <= jump && !tgt_bad;
        new_pc_q    <= (jump && !tgt_bad) ? tgt : next_pc;
        ins_len_q   <= len_d;
        range_err_q <= tgt_bad || code_bad;
        bad_op_q    <= !known;
        mem_addr_q  <= ptr16;
        mem_wdata_q <= accum_q;
        pend_dat_q  <= next_pc[15:8];
      end
    end
  end

  // Pushes and calls step the pointer before storing, so it names the
  // last byte used; a call stores its high byte one cycle later.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_top_q <= cmac_pkg::STACK_RST;
      ptr_lo_q    <= cmac_pkg::REG_RST;
      ptr_hi_q    <= cmac_pkg::REG_RST;
      accum_q     <= cmac_pkg::REG_RST;
      mulb_q      <= cmac_pkg::REG_RST;
      flags_q     <= cmac_pkg::REG_RST;
      store_ctl_q <= cmac_pkg::REG_RST;
    end else begin
      if (pend_q || (ok && (push || call))) begin
        stack_top_q <= stack_inc;
      end
      if (ok) begin
        flags_q[cmac_pkg::FLAGS_CY] <= cy_d;
      end
      if (fr_we) begin
        case (wr_adr)
          cmac_pkg::FR_STACK:     stack_top_q <= wr_dat;
          cmac_pkg::FR_PTR_LO:    ptr_lo_q    <= wr_dat;
          cmac_pkg::FR_PTR_HI:    ptr_hi_q    <= wr_dat;
          cmac_pkg::FR_STORE_CTL: store_ctl_q <= wr_dat;
          cmac_pkg::FR_FLAGS:     flags_q     <= wr_dat;
          cmac_pkg::FR_ACCUM:     accum_q     <= wr_dat;
          cmac_pkg::FR_MULB:      mulb_q      <= wr_dat;
          default:                accum_q     <= accum_q;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_CJMP_TAKEN: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_cjmp && jump |-> ##2 !done_q ##1 done_q)
    else $error("taken carry or zero jump did not end in three cycles");
  AST_CJMP_FALL: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_cjmp && !jump |-> ##1 !done_q ##1 done_q)
    else $error("untaken carry or zero jump did not end in two cycles");
  AST_JBC_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && opc == cmac_pkg::OP_JBC && bit_val
      |-> wr_en && !wr_dat[bit_adr[2:0]] ##4 done_q)
    else $error("bit jump with clear misbehaved");
  AST_JIND: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && opc == cmac_pkg::OP_JMP_IND && !tgt_bad
      |-> ##3 (done_q && new_pc_q == $past(jind_tgt, 3)))
    else $error("indirect jump target or timing wrong");
  AST_CJNE_TAKEN: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_cjne && jump |-> ##1 busy_q [*4] ##1 done_q)
    else $error("indirect compare jump not five cycles");
  AST_DJNZ_FALL: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_djnz && !jump |-> ##2 done_q)
    else $error("decrement jump fall-through not two cycles");
  AST_SJMP: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && opc == cmac_pkg::OP_SJMP && !tgt_bad |-> ##3 (done_q && taken_q))
    else $error("short jump not three cycles");
  AST_REL_TGT: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && opc == cmac_pkg::OP_SJMP && !tgt_bad
      |=> new_pc_q == $past(next_pc) + {{8{$past(ins_arg1[7])}},
                                        $past(ins_arg1)})
    else $error("relative target wrong");
  AST_PAGE: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && is_ajmp && !tgt_bad
      |=> new_pc_q[15:11] == $past(next_pc[15:11]))
    else $error("page jump left its page");
  AST_PUSH: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && push |=> stack_top_q == $past(stack_top_q) + 8'h01)
    else $error("push did not advance the stack pointer");
  AST_STACK_RESET: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> stack_top_q == cmac_pkg::STACK_RST)
    else $error("stack pointer reset value wrong");
  AST_PSWE: assert property (@(posedge mclk) disable iff (!reset_n)
    ok && ext_wr && code_sel |=> !xdata_we_q)
    else $error("external write escaped while program store enabled");

endmodule
`default_nettype wire

// ==== verilog/cmac_pkg.sv ====
// Constants, opcodes and types shared by the addressing core files.
package cmac_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_SPARE      = 8'hA5;
  localparam logic [7:0] OP_SJMP       = 8'h80;
  localparam logic [7:0] OP_JC         = 8'h40;
  localparam logic [7:0] OP_JNC        = 8'h50;
  localparam logic [7:0] OP_JZ         = 8'h60;
  localparam logic [7:0] OP_JNZ        = 8'h70;
  localparam logic [7:0] OP_JB         = 8'h20;
  localparam logic [7:0] OP_JNB        = 8'h30;
  localparam logic [7:0] OP_JBC        = 8'h10;
  localparam logic [7:0] OP_JMP_IND    = 8'h73;
  localparam logic [7:0] OP_CJNE_IND   = 8'hB6;
  localparam logic [7:0] OP_DJNZ_REG   = 8'hD8;
  localparam logic [7:0] OP_CLR_BIT    = 8'hC2;
  localparam logic [7:0] OP_SETB_BIT   = 8'hD2;
  localparam logic [7:0] OP_CPL_BIT    = 8'hB2;
  localparam logic [7:0] OP_ANL_C      = 8'h82;
  localparam logic [7:0] OP_ANL_NC     = 8'hB0;
  localparam logic [7:0] OP_ORL_C      = 8'h72;
  localparam logic [7:0] OP_ORL_NC     = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT  = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C  = 8'h92;
  localparam logic [7:0] OP_PUSH       = 8'hC0;
  localparam logic [7:0] OP_MOVX_PTR   = 8'hF0;
  localparam logic [7:0] OP_MOV_DIR_IM = 8'h75;
  localparam logic [7:0] OP_MOV_IND_IM = 8'h76;
  localparam logic [7:0] OP_MOV_REG_IM = 8'h78;
  localparam logic [7:0] OP_LJMP       = 8'h02;
  localparam logic [4:0] OPL_AJMP      = 5'h01;
  localparam logic [4:0] OPL_ACALL     = 5'h11;

  // ****************************************************************
  // Function register addresses, fields and reset values
  // ****************************************************************
  localparam logic [7:0] FR_STACK      = 8'h81;
  localparam logic [7:0] FR_PTR_LO     = 8'h82;
  localparam logic [7:0] FR_PTR_HI     = 8'h83;
  localparam logic [7:0] FR_STORE_CTL  = 8'h8F;
  localparam logic [7:0] FR_FLAGS      = 8'hD0;
  localparam logic [7:0] FR_ACCUM      = 8'hE0;
  localparam logic [7:0] FR_MULB       = 8'hF0;
  localparam logic [7:0] STACK_RST     = 8'h07;
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam int         FLAGS_CY      = 7;
  localparam int         FLAGS_BANK_HI = 4;
  localparam int         FLAGS_BANK_LO = 3;
  localparam int         STORE_WE      = 0;
  localparam logic [7:0] BIT_BASE      = 8'h20;
  localparam logic [15:0] CODE_LIMIT = 16'h3DFF;

  // ****************************************************************
  // Lengths and cycle counts
  // ****************************************************************
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_ONE     = 3'h1;
  localparam logic [2:0] CYC_CJMP_NT = 3'h2;
  localparam logic [2:0] CYC_CJMP_T  = 3'h3;
  localparam logic [2:0] CYC_JBIT_NT = 3'h3;
  localparam logic [2:0] CYC_JBIT_T  = 3'h4;
  localparam logic [2:0] CYC_JIND    = 3'h3;
  localparam logic [2:0] CYC_CJNE_NT = 3'h4;
  localparam logic [2:0] CYC_CJNE_T  = 3'h5;
  localparam logic [2:0] CYC_DJNZ_NT = 3'h2;
  localparam logic [2:0] CYC_DJNZ_T  = 3'h3;
  localparam logic [2:0] CYC_SJMP    = 3'h3;
  localparam logic [2:0] CYC_BITOP   = 3'h2;
  localparam logic [2:0] CYC_PAGE    = 3'h3;
  localparam logic [2:0] CYC_LJMP    = 3'h4;
  localparam logic [2:0] CYC_PUSH    = 3'h2;
  localparam logic [2:0] CYC_MOVX    = 3'h3;
  localparam logic [2:0] CYC_MOV_DIR = 3'h3;
  localparam logic [2:0] CYC_MOV_2   = 3'h2;

  typedef enum logic {ST_IDLE, ST_RUN} cmac_state_t;

endpackage

// ==== verilog/cmac_data_ram.sv ====
// Internal 256-byte data memory with two read ports and one write port.
`timescale 1ns/100ps
`default_nettype none
module cmac_data_ram (
  input  wire logic       mclk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr_a,
  output logic      [7:0] rdata_a,
  input  wire logic [7:0] raddr_b,
  output logic      [7:0] rdata_b
);

  // Asynchronous reads let the pointer fetch feed the indirect fetch in
  // one cycle; the cost is a deeper combinational path.
  logic [7:0] mem [0:255];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

// ==== test/cmac_core_test.sv ====
// Self-checking bench for the branch and addressing core.
`timescale 1ns/100ps
`default_nettype none
module cmac_core_test;
  logic        mclk, reset_n, issue, busy_q, done_q, taken_q;
  logic        range_err_q, bad_op_q, xdata_we_q, code_we_q, xw, cw;
  logic [7:0]  ins_op, ins_arg1, ins_arg2, mem_wdata_q;
  logic [15:0] next_pc, new_pc_q, mem_addr_q;
  logic [1:0]  ins_len_q;
  int          err_count = 0;
  int          comparisons = 0;

  cmac_core dut_u (.mclk(mclk), .reset_n(reset_n), .issue(issue),
    .ins_op(ins_op), .ins_arg1(ins_arg1), .ins_arg2(ins_arg2),
    .next_pc(next_pc), .busy_q(busy_q), .done_q(done_q),
    .taken_q(taken_q), .new_pc_q(new_pc_q), .ins_len_q(ins_len_q),
    .range_err_q(range_err_q), .bad_op_q(bad_op_q),
    .xdata_we_q(xdata_we_q), .code_we_q(code_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task finish_test;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // ****************************************************************
  // Issue one instruction and time it from the taking edge to done.
  // ****************************************************************
  task ex(input logic [23:0] ins, input logic [15:0] np,
          input logic [15:0] pc, input int cyc, input logic tk,
          input logic [1:0] len);
    int n;
    {ins_op, ins_arg1, ins_arg2} = ins;
    next_pc = np;
    issue = 1'b1;
    @(posedge mclk);
    #1 issue = 1'b0;
    xw = xdata_we_q;
    cw = code_we_q;
    chk("busy", {15'h0000, cyc > 1}, {15'h0000, busy_q});
    for (n = 1; n <= 8; n++) begin
      if (done_q === 1'b1) break;
      @(posedge mclk);
      #1;
    end
    if (n > 8) begin
      $display("[FAIL] done expected 1 seen 0");
      err_count++;
      finish_test();
    end
    chk("cycles", cyc[15:0], n[15:0]);
    chk("taken", {15'h0000, tk}, {15'h0000, taken_q});
    chk("new_pc", pc, new_pc_q);
    chk("length", {14'h0000, len}, {14'h0000, ins_len_q});
  endtask

  task op(input logic [23:0] ins, input int cyc, input logic [1:0] len);
    ex(ins, 16'h0100, 16'h0100, cyc, 1'b0, len);
  endtask

  initial begin
    {issue, ins_op, ins_arg1, ins_arg2, next_pc} = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1 reset_n = 1'b1;
    ex(24'hA50000, 16'h0101, 16'h0101, 1, 1'b0, 2'h1);
    chk("bad_op", 16'h0000, {15'h0000, bad_op_q});
    ex(24'h401000, 16'h0102, 16'h0102, 2, 1'b0, 2'h2);
    op(24'hD2D700, 2, 2'h2);
    ex(24'h40FE00, 16'h0200, 16'h01FE, 3, 1'b1, 2'h2);
    ex(24'h10D705, 16'h0300, 16'h0305, 4, 1'b1, 2'h3);
    ex(24'h401000, 16'h0302, 16'h0302, 2, 1'b0, 2'h2);
    ex(24'h808000, 16'h1000, 16'h0F80, 3, 1'b1, 2'h2);
    ex(24'hE13400, 16'h0802, 16'h0F34, 3, 1'b1, 2'h2);
    ex(24'h023E00, 16'h0103, 16'h0103, 4, 1'b0, 2'h3);
    chk("range_err", 16'h0001, {15'h0000, range_err_q});
    $display("Test branches done");
    op(24'h75E05A, 3, 2'h3);
    op(24'h758312, 3, 2'h3);
    op(24'h758234, 3, 2'h3);
    ex(24'h730000, 16'h0100, 16'h128E, 3, 1'b1, 2'h1);
    op(24'h780800, 2, 2'h2);
    op(24'hC0E000, 2, 2'h2);
    ex(24'hB65A04, 16'h0400, 16'h0400, 4, 1'b0, 2'h3);
    ex(24'hB65B04, 16'h0400, 16'h0404, 5, 1'b1, 2'h3);
    op(24'h75D008, 3, 2'h3);
    ex(24'hD81000, 16'h0500, 16'h0510, 3, 1'b1, 2'h2);
    op(24'h75D000, 3, 2'h3);
    ex(24'hB65904, 16'h0400, 16'h0400, 4, 1'b0, 2'h3);
    op(24'h780100, 2, 2'h2);
    ex(24'hD81000, 16'h0500, 16'h0500, 2, 1'b0, 2'h2);
    op(24'h788100, 2, 2'h2);
    op(24'h763300, 2, 2'h2);
    ex(24'hB63304, 16'h0400, 16'h0400, 4, 1'b0, 2'h3);
    op(24'hC0E000, 2, 2'h2);
    op(24'h780900, 2, 2'h2);
    ex(24'hB65A04, 16'h0400, 16'h0400, 4, 1'b0, 2'h3);
    op(24'h752200, 3, 2'h3);
    op(24'hD21300, 2, 2'h2);
    op(24'h782200, 2, 2'h2);
    ex(24'hB60804, 16'h0400, 16'h0400, 4, 1'b0, 2'h3);
    $display("Test data memory done");
    op(24'hF00000, 3, 2'h1);
    chk("xdata_we", 16'h0001, {15'h0000, xw});
    chk("mem_addr", 16'h1234, mem_addr_q);
    chk("mem_wdata", 16'h005A, {8'h00, mem_wdata_q});
    op(24'h758F01, 3, 2'h3);
    op(24'hF00000, 3, 2'h1);
    chk("code_we", 16'h0001, {15'h0000, cw});
    chk("xdata_we", 16'h0000, {15'h0000, xw});
    op(24'h75833E, 3, 2'h3);
    op(24'hF00000, 3, 2'h1);
    chk("code_we", 16'h0000, {15'h0000, cw});
    chk("range_err", 16'h0001, {15'h0000, range_err_q});
    op(24'hE40000, 1, 2'h1);
    chk("bad_op", 16'h0001, {15'h0000, bad_op_q});
    $display("Test program store done");
    finish_test();
  end
endmodule
`default_nettype wire
